// ===== common/tau_clk_cfg.svh
`ifndef TAU_CLK_CFG_SVH
`define TAU_CLK_CFG_SVH
// Register byte offsets on the AXI4-Lite bus
`define OFS_CLOCK_GATE      12'h000
`define OFS_PRESCALER       12'h004
`define OFS_CHAN_MODE       12'h008
`define OFS_STATUS          12'h00C
// Clock gate field
`define GATE_EN_BIT         0
// Prescaler select fields
`define PRS_A_LSB           0
`define PRS_B_LSB           4
`define PRS_C_LSB           8
`define PRS_D_LSB           12
// Writable prescaler bits; clocks c and d use two-bit fields
`define PRS_WMASK           16'h33FF
// Channel mode fields
`define CKS_LSB             14
`define CCS_BIT             12
`define MASTER_BIT          11
`define STS_LSB             8
`define CIS_LSB             6
`define MD_LSB              0
// Writable channel mode bits; 13, 5 and 4 stay zero
`define MODE_WMASK          16'hDFCF
// Reset values
`define GATE_RST            8'h00
`define PRS_RST             16'h0000
`define MODE_RST            16'h0000
// Bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`endif

// ===== common/tau_clk_pkg.sv
package tau_clk_pkg;
	// Input edge choices of a channel
	typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BOTH_L, EDGE_BOTH_H} edge_sel_t;
	// Bus write engine states
	typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_state_t;
endpackage

// ===== hdl/tau_prescaler.sv
`timescale 1ns/1ps
`include "tau_clk_cfg.svh"
// Free-running power-of-two divider with a one-cycle tick per divided period
module tau_prescaler
#(
	parameter int CNT_W = 15
)
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             run,
	input  wire logic [CNT_W-1:0] count,
	output logic      [CNT_W:0]   ticks
);
	logic [CNT_W-1:0]      cnt_q;
	// Net, since each bit has its own continuous driver from the generate loop
	wire logic [CNT_W:0]   ticks_d;
	// Select value is not needed here; every divided tick is offered to the caller
	logic [CNT_W-1:0]      unused_count;

	// Counter stops when the unit clock is gated, and every tick drops low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= '0;
		else if (run)
			cnt_q <= cnt_q + 1'b1;
	end

	// Tick k fires when the low k bits are all ones; k = 0 fires every cycle
	genvar k;
	generate
		for (k = 0; k <= CNT_W; k++)
		begin : g_tick
			if (k == 0)
			begin : g_zero
				assign ticks_d[k] = run;
			end
			else
			begin : g_div
				assign ticks_d[k] = run && (&cnt_q[k-1:0]);
			end
		end
	endgenerate

	// Registered tick vector
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ticks <= '0;
		else
			ticks <= ticks_d;
	end
	assign unused_count = count;
endmodule

// ===== hdl/tau_clock_select.sv
`timescale 1ns/1ps
`include "tau_clk_cfg.svh"
// Functional notes
// R1 - Gate bit zero enables unit clock
// R2 - Software enables clock before configuring
// R3 - Clock a divides system clock by 2^n
// R4 - Clock field picks a, c, b, d
// R5 - Count source: operation clock or pin edge
// R6 - Mode register fields, fixed zero bits
// R7 - Master flag makes channel zero master
// R8 - Clocks b, c, d from own fields
module tau_clock_select
	import tau_clk_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        timer_input_pin,
	output logic             unit_clock_on,
	output logic             channel_operation_tick,
	output logic             channel_count_tick,
	output logic             master_mode
);
	// Whole module state
	typedef struct packed {
		logic [7:0]  gate;
		logic [15:0] prs;
		logic [15:0] mode;
		logic        aw_got;
		logic [11:0] aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        pin_s1;
		logic        pin_s2;
		logic        pin_s3;
		logic        op_tick;
		logic        cnt_tick;
		logic        master;
		logic        clk_on;
	} state_t;

	state_t st_q;
	state_t st_d;
	logic [15:0] ticks;
	logic        pin_edge;
	logic        wr_fire;
	logic        ok_addr_w;
	logic        ok_addr_r;

	// Decode of mapped registers, shared by reads and writes
	function automatic logic mapped(input logic [11:0] a);
		if (a == `OFS_CLOCK_GATE)
			return 1'b1;
		else if (a == `OFS_PRESCALER)
			return 1'b1;
		else if (a == `OFS_CHAN_MODE)
			return 1'b1;
		else if (a == `OFS_STATUS)
			return 1'b1;
		else
			return 1'b0;
	endfunction

	// Byte-lane merge of a write into a stored value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction

	// Pick one of sixteen divided ticks by a select value
	function automatic logic pick(input logic [15:0] t, input logic [3:0] sel);
		return t[sel];
	endfunction

	// Prescaler chain; one counter serves all four clocks since all divide by 2^n
	tau_prescaler #(
		.CNT_W (15)
	) u_prescaler (
		.aclk    (aclk),
		.aresetn (aresetn),
		// R1 - gate feeds divider
		.run     (st_q.gate[`GATE_EN_BIT]),
		.count   (st_q.prs[14:0]),
		.ticks   (ticks)
	);

	assign ok_addr_w = mapped(st_q.aw_addr);
	assign ok_addr_r = mapped(s_axi_araddr);
	assign wr_fire   = st_q.aw_got && st_q.w_got && !st_q.bvalid;

	// Valid pin edge from the synchronised pin, per selected edge mode
	always_comb
	begin
		pin_edge = 1'b0;
		case (edge_sel_t'(st_q.mode[`CIS_LSB +: 2]))
			EDGE_FALL:   pin_edge = st_q.pin_s3 && !st_q.pin_s2;
			EDGE_RISE:   pin_edge = !st_q.pin_s3 && st_q.pin_s2;
			default:     pin_edge = st_q.pin_s3 != st_q.pin_s2;
		endcase
	end

	// Next-state logic for bus, registers and clock selection
	always_comb
	begin
		logic [31:0] m;
		logic        opk;
		m   = '0;
		opk = 1'b0;
		st_d = st_q;
		// Pin synchroniser; s1 is read only by s2
		st_d.pin_s1 = timer_input_pin;
		st_d.pin_s2 = st_q.pin_s1;
		st_d.pin_s3 = st_q.pin_s2;
		// Address and data accepted in either order
		if (s_axi_awvalid && !st_q.aw_got)
		begin
			st_d.aw_got  = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_q.w_got)
		begin
			st_d.w_got  = 1'b1;
			st_d.w_data = s_axi_wdata;
			st_d.w_strb = s_axi_wstrb;
		end
		if (wr_fire)
		begin
			st_d.aw_got = 1'b0;
			st_d.w_got  = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp  = ok_addr_w ? `RESP_OKAY : `RESP_SLVERR;
			if (st_q.aw_addr == `OFS_CLOCK_GATE)
			begin
				m = merge({24'h000000, st_q.gate}, st_q.w_data, st_q.w_strb);
				st_d.gate = m[7:0];
			end
			else if (st_q.aw_addr == `OFS_PRESCALER)
			begin
				// R8 - unused prescaler bits held zero
				m = merge({16'h0000, st_q.prs}, st_q.w_data, st_q.w_strb);
				st_d.prs = m[15:0] & `PRS_WMASK;
			end
			else if (st_q.aw_addr == `OFS_CHAN_MODE)
			begin
				// R6 - fixed-zero mode bits masked
				m = merge({16'h0000, st_q.mode}, st_q.w_data, st_q.w_strb);
				st_d.mode = m[15:0] & `MODE_WMASK;
			end
		end
		if (st_q.bvalid && s_axi_bready)
			st_d.bvalid = 1'b0;
		// Read path: one read at a time, answered the cycle after arvalid
		if (s_axi_arvalid && !st_q.rvalid)
		begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = ok_addr_r ? `RESP_OKAY : `RESP_SLVERR;
			if (s_axi_araddr == `OFS_CLOCK_GATE)
				st_d.rdata = {24'h000000, st_q.gate};
			else if (s_axi_araddr == `OFS_PRESCALER)
				st_d.rdata = {16'h0000, st_q.prs};
			else if (s_axi_araddr == `OFS_CHAN_MODE)
				st_d.rdata = {16'h0000, st_q.mode};
			else if (s_axi_araddr == `OFS_STATUS)
				st_d.rdata = {28'h0000000, st_q.master, st_q.cnt_tick, st_q.op_tick,
					st_q.clk_on};
			else
				st_d.rdata = '0;
		end
		else if (st_q.rvalid && s_axi_rready)
			st_d.rvalid = 1'b0;
		// R4 - operation clock chosen from four prescaled clocks
		case (st_q.mode[`CKS_LSB +: 2])
			// R3 - clock a divides by 2^field
			2'h0:    opk = pick(ticks, st_q.prs[`PRS_A_LSB +: 4]);
			// R8 - clock c from its two-bit field
			2'h1:    opk = pick(ticks, {2'h0, st_q.prs[`PRS_C_LSB +: 2]});
			2'h2:    opk = pick(ticks, st_q.prs[`PRS_B_LSB +: 4]);
			default: opk = pick(ticks, {2'h0, st_q.prs[`PRS_D_LSB +: 2]});
		endcase
		// R1 - no ticks while the unit clock is stopped
		st_d.clk_on  = st_q.gate[`GATE_EN_BIT];
		st_d.op_tick = opk && st_q.gate[`GATE_EN_BIT];
		// R5 - count source select
		if (st_q.mode[`CCS_BIT])
			st_d.cnt_tick = pin_edge && st_q.gate[`GATE_EN_BIT];
		else
			st_d.cnt_tick = opk && st_q.gate[`GATE_EN_BIT];
		// R7 - master flag drives master mode
		st_d.master = st_q.mode[`MASTER_BIT];
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q      <= '0;
			st_q.gate <= `GATE_RST;
			st_q.prs  <= `PRS_RST;
			st_q.mode <= `MODE_RST;
		end
		else
			st_q <= st_d;
	end

	// Outputs straight from flip-flops
	assign s_axi_awready          = !st_q.aw_got;
	assign s_axi_wready           = !st_q.w_got;
	assign s_axi_bvalid           = st_q.bvalid;
	assign s_axi_bresp            = st_q.bresp;
	assign s_axi_arready          = !st_q.rvalid;
	assign s_axi_rvalid           = st_q.rvalid;
	assign s_axi_rdata            = st_q.rdata;
	assign s_axi_rresp            = st_q.rresp;
	assign unit_clock_on          = st_q.clk_on;
	assign channel_operation_tick = st_q.op_tick;
	assign channel_count_tick     = st_q.cnt_tick;
	assign master_mode            = st_q.master;

	// Gate off stops all ticks
	property p_gate_off;
		@(posedge aclk) disable iff (!aresetn)
		!st_q.gate[0] |=> !channel_operation_tick && !channel_count_tick;
	endproperty
	chk_gate_stops_ticks: assert property (p_gate_off) else $error("tick while gated"); // R1
	// Divide by one ticks every cycle when enabled
	chk_div_one_rate: assert property (@(posedge aclk) disable iff (!aresetn) // R3
		st_q.gate[0] && $past(st_q.gate[0]) && st_q.mode[15:14] == 2'h0 && st_q.prs[3:0] == 4'h0
		&& $stable(st_q.mode) && $stable(st_q.prs) |=> channel_operation_tick)
		else $error("divide by one missed a tick");
	// Select 01 with field c zero behaves as divide by one
	chk_sel_c_path: assert property (@(posedge aclk) disable iff (!aresetn) // R4
		st_q.gate[0] && $past(st_q.gate[0]) && st_q.mode[15:14] == 2'h1 && st_q.prs[9:8] == 2'h0
		&& $stable(st_q.mode) && $stable(st_q.prs) |=> channel_operation_tick)
		else $error("clock c select wrong");
	// Internal count source follows the operation tick
	chk_count_src_int: assert property (@(posedge aclk) disable iff (!aresetn) // R5
		!st_q.mode[12] && $stable(st_q.mode) |=> channel_count_tick == channel_operation_tick)
		else $error("count tick not operation tick");
	// Fixed-zero mode bits never set
	chk_mode_zero_bits: assert property (@(posedge aclk) disable iff (!aresetn) // R6
		st_q.mode[13] == 1'b0 && st_q.mode[5:4] == 2'h0) else $error("fixed bit set");
	// Master output follows the flag one cycle later
	chk_master_follow: assert property (@(posedge aclk) disable iff (!aresetn) // R7
		1'b1 |=> master_mode == $past(st_q.mode[11])) else $error("master flag lost");
	// Unused prescaler bits read as zero
	chk_prs_zero_bits: assert property (@(posedge aclk) disable iff (!aresetn) // R8
		(st_q.prs & ~`PRS_WMASK) == 16'h0000) else $error("unused prescaler bit set");
	// Write response arrives the cycle after both halves are held
	sequence s_both_held;
		st_q.aw_got && st_q.w_got && !st_q.bvalid;
	endsequence
	chk_write_resp_time: assert property (@(posedge aclk) disable iff (!aresetn)
		s_both_held |=> s_axi_bvalid) else $error("write response late");
endmodule

// ===== testbench/tau_clock_select_bench.sv
`timescale 1ns/1ps
`include "tau_clk_cfg.svh"
module tau_clock_select_bench;
	logic        aclk = 1'b0;     // Bus and logic clock
	logic        aresetn = 1'b0;  // Held low first
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, pin = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	logic        clk_on, otick, ctick, master;
	int          num_errors = 0, num_checks = 0;
	tau_clock_select dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .timer_input_pin(pin), .unit_clock_on(clk_on),
		.channel_operation_tick(otick), .channel_count_tick(ctick), .master_mode(master));
	// Free-running 100 MHz clock
	always #5 aclk = ~aclk;
	// Closing report, the only exit
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Four-state compare; an unknown bit matches only an unknown bit in exp
	task expect_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Ready and valid are sampled at the falling edge, since they only move on rising edges
	task bus_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_go, w_go, b_go;
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_go = 0;
		for (n = 0; n < 100 && !b_go; n++)
		begin
			@(negedge aclk);
			aw_go = awvalid && awready;
			w_go = wvalid && wready;
			b_go = bvalid && bready;
			r = bresp;
			@(posedge aclk);
			if (aw_go) awvalid <= 1'b0;
			if (w_go) wvalid <= 1'b0;
			if (b_go) bready <= 1'b0;
		end
		if (!b_go)
		begin
			num_errors++;
			$display("mismatch at %0t: write response timed out", $time);
			print_verdict();
		end
	endtask
	// Read with the same edge discipline
	task bus_read(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		bit ar_go, r_go;
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r_go = 0;
		for (n = 0; n < 100 && !r_go; n++)
		begin
			@(negedge aclk);
			ar_go = arvalid && arready;
			r_go = rvalid && rready;
			rd = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ar_go) arvalid <= 1'b0;
			if (r_go) rready <= 1'b0;
		end
		if (!r_go)
		begin
			num_errors++;
			$display("mismatch at %0t: read response timed out", $time);
			print_verdict();
		end
		expect_val(rd, exp);
		expect_val(rsp, er);
	endtask
	// Write that must be accepted
	task write_ok(input logic [11:0] a, input logic [31:0] d);
		bus_write(a, d, rsp);
		expect_val(rsp, `RESP_OKAY);
		// Outputs launched at the response edge are compared only once settled
		@(negedge aclk);
	endtask
	// Gap between two ticks, bounded so a dead tick shows as a wrong count
	task tick_period(input bit sel, input int exp);
		int c;
		c = 0;
		do
		begin
			@(negedge aclk);
			c++;
		end while (!(sel ? ctick : otick) && c < 300);
		c = 0;
		do
		begin
			@(negedge aclk);
			c++;
		end while (!(sel ? ctick : otick) && c < 300);
		expect_val(c, exp);
	endtask
	// Reset state, unmapped place and field masks
	task t_regs;
		bus_read(`OFS_CLOCK_GATE, 32'h0, `RESP_OKAY);
		bus_read(`OFS_CHAN_MODE, 32'h0, `RESP_OKAY);
		bus_read(12'h010, 32'h0, `RESP_SLVERR);
		bus_write(12'h010, 32'hFFFFFFFF, rsp);
		expect_val(rsp, `RESP_SLVERR);
		write_ok(`OFS_CLOCK_GATE, 32'h1);
		write_ok(`OFS_PRESCALER, 32'hFFFFFFFF);
		bus_read(`OFS_PRESCALER, 32'h33FF, `RESP_OKAY);
		write_ok(`OFS_CHAN_MODE, 32'hFFFFFFFF);
		bus_read(`OFS_CHAN_MODE, 32'hDFCF, `RESP_OKAY);
		expect_val(master, 1'b1);
		write_ok(`OFS_CHAN_MODE, 32'h0);
		expect_val(master, 1'b0);
	endtask
	// Gate on lets ticks run, gate off stops the operation tick
	task t_gate;
		int k, cnt;
		write_ok(`OFS_PRESCALER, 32'h0);
		write_ok(`OFS_CLOCK_GATE, 32'h1);
		expect_val(clk_on, 1'b1);
		bus_read(`OFS_STATUS, 32'h7, `RESP_OKAY);
		tick_period(0, 1);
		write_ok(`OFS_CLOCK_GATE, 32'h0);
		cnt = 0;
		for (k = 0; k < 40; k++)
		begin
			@(negedge aclk);
			if (otick !== 1'b0) cnt++;
		end
		expect_val(cnt, 0);
		expect_val(clk_on, 1'b0);
		write_ok(`OFS_CLOCK_GATE, 32'h1);
	endtask
	// Divide by two to the power of the field, and each clock selector code
	task t_divide;
		int n;
		int per[4] = '{1, 4, 2, 8};
		for (n = 0; n < 6; n++)
		begin
			write_ok(`OFS_PRESCALER, n);
			tick_period(0, 1 << n);
		end
		// Clock c with its field at zero runs undivided
		write_ok(`OFS_CHAN_MODE, 32'h4000);
		tick_period(0, 1);
		write_ok(`OFS_PRESCALER, 32'h3210);
		for (n = 0; n < 4; n++)
		begin
			write_ok(`OFS_CHAN_MODE, n << 14);
			tick_period(0, per[n]);
			tick_period(1, per[n]);
		end
	endtask
	// Pin edges drive the count tick for every edge choice
	task t_pin;
		int m, k, cnt;
		int exp[4] = '{3, 3, 6, 6};
		write_ok(`OFS_PRESCALER, 32'h000F);
		for (m = 0; m < 4; m++)
		begin
			write_ok(`OFS_CHAN_MODE, 32'h1000 | (m << 6));
			repeat (8) @(posedge aclk);
			cnt = 0;
			for (k = 0; k < 70; k++)
			begin
				@(posedge aclk);
				pin <= (k < 60) && (k % 20 < 10);
				@(negedge aclk);
				if (ctick) cnt++;
			end
			expect_val(cnt, exp[m]);
		end
	endtask
	// Main sequence
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_gate();
		t_divide();
		t_pin();
		print_verdict();
	end
endmodule
